// file: shared/shutdown_pkg.sv
package shutdown_pkg;

    // byte addresses of the apb registers
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_MODE   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK   = 8'h0c;
    localparam logic [7:0] ADDR_LIVE   = 8'h10;

    // ctrl register fields
    localparam int CTRL_SW_CMP    = 0;
    localparam int CTRL_SW_CH0    = 1;
    localparam int CTRL_OSC_EN    = 2;
    localparam int CTRL_EVT_EN    = 3;
    localparam int CTRL_CMP_EN    = 4;
    localparam int CTRL_ACT_HIGH  = 5;

    // mode register: per input 3 bits {rate[1:0], level}
    localparam int MODE_FIELD_W   = 3;

    // status / mask layout
    localparam int ST_FAULT_LSB   = 0;   // bits 4:0 fault inputs a..d, ch0
    localparam int ST_CMP         = 5;
    localparam int ST_OSC         = 6;
    localparam int ST_SW          = 7;
    localparam int ST_EVT         = 8;
    localparam int ST_W           = 9;

    // low-level sampling
    localparam int LOW_SAMPLES    = 16;
    localparam int DIV_SLOW_8     = 8;
    localparam int DIV_SLOW_16    = 16;
    localparam int DIV_SLOW_128   = 128;

    localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
    localparam logic [31:0] RESET_MODE = 32'h0000_0000;
    localparam logic [31:0] RESET_MASK = 32'h0000_0000;

endpackage

// file: src/fault_detector.sv
`timescale 1ns/100ps
module fault_detector
    import shutdown_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       fault_n,
    input  wire logic       level_mode,
    input  wire logic [1:0] rate,
    output logic            detect
);

    logic [6:0] div_count;
    logic [4:0] low_count;
    logic       fault_q;
    logic       tick;
    logic       fall;
    logic [6:0] div_last;

    assign div_last = (rate == 2'd0) ? 7'(DIV_SLOW_8 - 1)
                    : (rate == 2'd1) ? 7'(DIV_SLOW_16 - 1)
                    : 7'(DIV_SLOW_128 - 1);
    assign tick = (div_count >= div_last);
    assign fall = fault_q & ~fault_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 7'h00;
            low_count <= 5'h00;
            fault_q   <= 1'b1;
            detect    <= 1'b0;
        end else begin
            fault_q   <= fault_n;
            div_count <= tick ? 7'h00 : div_count + 7'h01; // [RULE_02]
            if (fault_n)
                low_count <= 5'h00;
            else if (tick && low_count < 5'(LOW_SAMPLES))
                low_count <= low_count + 5'h01; // [RULE_02]
            detect <= level_mode ? (low_count == 5'(LOW_SAMPLES))
                                 : fall; // [RULE_01]
        end
    end

    low_needs_16_a: assert property (@(posedge pclk) disable iff (!presetn)
        (level_mode && $rose(detect)) |-> $past(low_count) == 5'd16) // [RULE_02]
        else $error("level detect before sixteen low samples");

endmodule // fault_detector

// file: src/output_shutdown_block.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
// Behaviour
// [RULE_01] each fault input selects falling-edge or low-level detection
// [RULE_02] low-level mode samples at pclk/8, /16 or /128; 16 lows fault
// [RULE_03] any fault input a..d floats the complementary pwm pins
// [RULE_04] the channel-0 fault input floats the channel-0 timer pins
// [RULE_05] both pair members active together floats the complementary pins
// [RULE_06] oscillator stop can float both pin groups
// [RULE_07] software register write floats both pin groups immediately
// [RULE_08] event-link signal can float both pin groups
// [RULE_09] interrupts on fault detection and on output comparison
// [RULE_10] causes latch in status; pins float until software clears
module output_shutdown_block
    import shutdown_pkg::*;
#(
    parameter int PAIRS = 3
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              fault_in_a,
    input  wire logic              fault_in_b,
    input  wire logic              fault_in_c,
    input  wire logic              fault_in_d,
    input  wire logic              fault_in_ch0,
    input  wire logic              osc_stopped,
    input  wire logic              elc_event,
    input  wire logic [PAIRS-1:0]  pwm_pos,
    input  wire logic [PAIRS-1:0]  pwm_neg,
    output logic                   cmp_pins_hiz,
    output logic                   ch0_pins_hiz,
    output logic                   irq
);

    logic [31:0]     ctrl;
    logic [14:0]     mode;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [4:0]      detect;
    logic [4:0]      fault_pins;
    logic [ST_W-1:0] events;
    logic [ST_W-1:0] next_status;
    logic [ST_W-1:0] clear_bits;
    logic [PAIRS-1:0] pos_act;
    logic [PAIRS-1:0] neg_act;
    logic            overlap;
    logic            wr_en;
    logic            rd_en;
    logic            addr_ok;
    logic            sw_write;
    logic            osc_hit;
    logic            evt_hit;

    assign fault_pins = {fault_in_ch0, fault_in_d, fault_in_c,
                         fault_in_b, fault_in_a};

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : gen_det
            fault_detector u_det (
                .pclk       (pclk),
                .presetn    (presetn),
                .fault_n    (fault_pins[g]),
                .level_mode (mode[g*MODE_FIELD_W]), // [RULE_01]
                .rate       (mode[g*MODE_FIELD_W+1 +: 2]),
                .detect     (detect[g])
            );
        end
    endgenerate

    // apb slave: zero wait states, error on unmapped address
    assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_MODE)
                  || (paddr == ADDR_STATUS) || (paddr == ADDR_MASK)
                  || (paddr == ADDR_LIVE);
    assign wr_en   = psel & penable & pwrite & addr_ok;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    // active level selectable, since pwm polarity differs by board
    assign pos_act = ctrl[CTRL_ACT_HIGH] ? pwm_pos : ~pwm_pos;
    assign neg_act = ctrl[CTRL_ACT_HIGH] ? pwm_neg : ~pwm_neg;
    assign overlap = ctrl[CTRL_CMP_EN] & |(pos_act & neg_act); // [RULE_05]

    assign sw_write = wr_en && paddr == ADDR_CTRL
                   && (pwdata[CTRL_SW_CMP] || pwdata[CTRL_SW_CH0]); // [RULE_07]
    assign osc_hit  = ctrl[CTRL_OSC_EN] & osc_stopped; // [RULE_06]
    assign evt_hit  = ctrl[CTRL_EVT_EN] & elc_event;   // [RULE_08]

    assign events = {evt_hit, sw_write, osc_hit, overlap, detect};

    // set wins over a write-one clear arriving in the same cycle
    assign clear_bits  = (wr_en && paddr == ADDR_STATUS)
                       ? pwdata[ST_W-1:0] : '0;
    assign next_status = (status & ~clear_bits) | events; // [RULE_10]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= RESET_CTRL;
            mode   <= RESET_MODE[14:0];
            mask   <= RESET_MASK[ST_W-1:0];
            status <= '0;
        end else begin
            status <= next_status;
            if (wr_en && paddr == ADDR_CTRL)
                ctrl <= pwdata;
            if (wr_en && paddr == ADDR_MODE)
                mode <= pwdata[14:0];
            if (wr_en && paddr == ADDR_MASK)
                mask <= pwdata[ST_W-1:0];
        end
    end

    // pins stay floated while a latched fault, cmp, osc or evt cause is pending (status sw bit floats nothing); sw bits of
    // ctrl hold the software request until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_pins_hiz <= 1'b0;
            ch0_pins_hiz <= 1'b0;
        end else begin
            cmp_pins_hiz <= |next_status[3:0]               // [RULE_03]
                          | next_status[ST_CMP]             // [RULE_05]
                          | next_status[ST_OSC]             // [RULE_06]
                          | next_status[ST_EVT]             // [RULE_08]
                          | (sw_write ? pwdata[CTRL_SW_CMP]
                                      : ctrl[CTRL_SW_CMP]);  // [RULE_07]
            ch0_pins_hiz <= next_status[4]                  // [RULE_04]
                          | next_status[ST_OSC]
                          | next_status[ST_EVT]
                          | (sw_write ? pwdata[CTRL_SW_CH0]
                                      : ctrl[CTRL_SW_CH0]);
        end
    end

    assign irq = |(status & mask); // [RULE_09]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en) begin
            case (paddr)
                ADDR_CTRL:   prdata <= ctrl;
                ADDR_MODE:   prdata <= {17'h00000, mode};
                ADDR_STATUS: prdata <= {23'h000000, status};
                ADDR_MASK:   prdata <= {23'h000000, mask};
                ADDR_LIVE:   prdata <= {27'h0000000, fault_pins};
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    fault_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        |detect[3:0] |=> cmp_pins_hiz) // [RULE_03]
        else $error("fault a..d did not float pwm pins");

    ch0_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        detect[4] |=> ch0_pins_hiz) // [RULE_04]
        else $error("ch0 fault did not float ch0 pins");

    overlap_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        overlap |=> cmp_pins_hiz && status[ST_CMP]) // [RULE_05]
        else $error("pwm overlap not caught");

    osc_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        osc_hit |=> cmp_pins_hiz && ch0_pins_hiz) // [RULE_06]
        else $error("oscillator stop not floating pins");

    sw_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_write && pwdata[CTRL_SW_CH0] |=> ch0_pins_hiz) // [RULE_07]
        else $error("software shutdown not applied");

    event_float_a: assert property (@(posedge pclk) disable iff (!presetn)
        evt_hit |=> ##1 status[ST_EVT] && ch0_pins_hiz) // [RULE_08]
        else $error("event shutdown not held");

    irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        (detect[0] && mask[0]) |=> irq) // [RULE_09]
        else $error("fault detection gave no interrupt");

    latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (status[ST_CMP] && !clear_bits[ST_CMP]) |=> status[ST_CMP]) // [RULE_10]
        else $error("status flag lost without clear");

endmodule // output_shutdown_block

// file: tb/port_output_enable_tb_top.sv
`timescale 1ns/100ps
module port_output_enable_tb_top;
    import shutdown_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic        pready, pslverr, cmp_pins_hiz, ch0_pins_hiz, irq, err_v;
    logic [4:0]  drop_req, fault_n;
    logic        overlap, osc_req, evt_req, osc_stopped, elc_event;
    logic [2:0]  pwm_pos, pwm_neg;
    int          n_errors, checks_done, cycles, div;
    output_shutdown_block dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .fault_in_a(fault_n[0]), .fault_in_b(fault_n[1]),
        .fault_in_c(fault_n[2]), .fault_in_d(fault_n[3]),
        .fault_in_ch0(fault_n[4]), .osc_stopped, .elc_event(elc_event),
        .pwm_pos, .pwm_neg, .cmp_pins_hiz, .ch0_pins_hiz, .irq);
    timer_fault_partner partner (.pclk, .presetn, .drop_req, .overlap,
        .osc_req, .evt_req, .fault_n, .osc_stopped, .elc_event,
        .pwm_pos, .pwm_neg);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_v, exp);
    endtask
    // wait bounded for the two float outputs, sampled mid-cycle
    task automatic wait_hiz(input logic [1:0] e, input int n);
        int k;
        k = 0;
        @(negedge pclk);
        while ({cmp_pins_hiz, ch0_pins_hiz} !== e && k < n) begin
            @(negedge pclk);
            k++;
        end
        chk({30'h0, cmp_pins_hiz, ch0_pins_hiz}, {30'h0, e});
    endtask
    task automatic clear_all;
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h1ff);
        wait_hiz(2'b00, 4);
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            wrap_up;
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {drop_req, overlap, osc_req, evt_req} = '0;
        {n_errors, checks_done, cycles} = '0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL, RESET_CTRL);
        rd(ADDR_MODE, RESET_MODE);
        rd(ADDR_MASK, RESET_MASK);
        rd(ADDR_STATUS, 32'h0);
        rd(8'h14, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            drop_req <= 5'(1 << i);
            repeat (3) @(posedge pclk);
            drop_req <= 5'h0;
            wait_hiz(2'b10, 8);
            rd(ADDR_STATUS, 32'(1 << i));
            clear_all;
        end
        drop_req <= 5'h10;
        repeat (3) @(posedge pclk);
        drop_req <= 5'h0;
        wait_hiz(2'b01, 8);
        clear_all;
        // a low held 14 sample periods must not trip ch0 yet, at each of /8, /16 and /128
        for (int r = 0; r < 3; r++) begin
            div = (r == 0) ? DIV_SLOW_8 : (r == 1) ? DIV_SLOW_16 : DIV_SLOW_128;
            apb(1'b1, ADDR_MODE, 32'(((r << 1) | 1) << 12));
            drop_req <= 5'h10;
            repeat ((LOW_SAMPLES - 2) * div) @(posedge pclk);
            wait_hiz(2'b00, 0);
            wait_hiz(2'b01, 3 * div + 10);
            drop_req <= 5'h0;
            rd(ADDR_STATUS, 32'h10);
            clear_all;
        end
        apb(1'b1, ADDR_CTRL, 32'h30);
        apb(1'b1, ADDR_MASK, 32'h20);
        overlap <= 1'b1;
        repeat (2) @(posedge pclk);
        overlap <= 1'b0;
        wait_hiz(2'b10, 8);
        chk({31'h0, irq}, 32'h1);
        rd(ADDR_STATUS, 32'h20);
        apb(1'b1, ADDR_MASK, 32'h0);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        clear_all;
        apb(1'b1, ADDR_CTRL, 32'h4);
        osc_req <= 1'b1;
        wait_hiz(2'b11, 8);
        osc_req <= 1'b0;
        clear_all;
        apb(1'b1, ADDR_CTRL, 32'h8);
        evt_req <= 1'b1;
        @(posedge pclk);
        evt_req <= 1'b0;
        wait_hiz(2'b11, 8);
        rd(ADDR_STATUS, 32'h100);
        clear_all;
        apb(1'b1, ADDR_CTRL, 32'h3);
        wait_hiz(2'b11, 2);
        clear_all;
        wrap_up;
    end
endmodule // port_output_enable_tb_top

// file: tb/timer_fault_partner.sv
`timescale 1ns/100ps
module timer_fault_partner #(
    parameter int PAIRS = 3
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [4:0]       drop_req,
    input  wire logic             overlap,
    input  wire logic             osc_req,
    input  wire logic             evt_req,
    output logic      [4:0]       fault_n,
    output logic                  osc_stopped,
    output logic                  elc_event,
    output logic      [PAIRS-1:0] pwm_pos,
    output logic      [PAIRS-1:0] pwm_neg
);
    logic phase;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) phase <= 1'b0;
        else phase <= ~phase;
    end
    // fault lines are pulled up, so a released line reads high
    assign fault_n     = ~drop_req;
    assign osc_stopped = osc_req;
    assign elc_event   = evt_req;
    // complementary pair keeps members opposite unless told to overlap
    assign pwm_pos     = {PAIRS{phase}};
    assign pwm_neg     = overlap ? pwm_pos : ~pwm_pos;
endmodule // timer_fault_partner
